//--- hw/sdb_pkg.sv
// shared constants for the stall detect bridge and countdown block
package sdb_pkg;
  // register indices (byte wide registers, one per address)
  localparam logic [2:0] ADDR_RTZ_CTL = 3'h0; // step, integrate, drive, recirc, polarity
  localparam logic [2:0] ADDR_CD_CTL = 3'h1;  // countdown_control
  localparam logic [2:0] ADDR_SSD_CTL = 3'h2; // return_zero_enable
  localparam logic [2:0] ADDR_FLAGS = 3'h3;   // underflow_flag, overflow_flag
  localparam logic [2:0] ADDR_CNT_HI = 3'h4;  // countdown_value high byte
  localparam logic [2:0] ADDR_CNT_LO = 3'h5;  // countdown_value low byte
  // countdown_control bit positions
  localparam int BIT_UF_IE = 7;
  localparam int BIT_AUTO = 6;
  localparam int BIT_RDLOAD = 5;
  localparam int BIT_PRE = 4;
  localparam int BIT_FORCE = 3;
  localparam int BIT_EN = 2;
  localparam int BIT_OV_IE = 0;
  // return-to-zero control bit positions
  localparam int BIT_ITG = 7;
  localparam int BIT_DRIVE_COIL_SELECT = 6;
  localparam int BIT_RECIRC_LOW_SIDE = 5;
  localparam int BIT_POL = 4;
  // flags and enable positions
  localparam int BIT_UF_FLAG = 7;
  localparam int BIT_OV_FLAG = 0;
  localparam int BIT_RETURN_ZERO_ENABLE = 7;
  // reset values and the zero count
  localparam logic [7:0] RST_CTL = 8'h00;
  localparam logic [15:0] CNT_PRESET = 16'hffff;
  localparam logic [15:0] CNT_ZERO = 16'h0000;
  // prescaler divide counts
  localparam logic [8:0] DIV_FAST = 9'h03f; // 64 - 1
  localparam logic [8:0] DIV_SLOW = 9'h1ff; // 512 - 1
endpackage : sdb_pkg

//--- hw/sdb_bridge_dec.sv
`timescale 1ns/1ps
`default_nettype none
// registered decode of step state into transistor and switch enables
module sdb_bridge_dec (
  input wire logic clk_sys_i,
  input wire logic rst_i,
  input wire logic rtz_en_i,
  input wire logic [1:0] step_i,
  input wire logic itg_i,
  input wire logic drive_coil_select_i,
  input wire logic recirc_low_side_i,
  input wire logic pol_i,
  output logic [7:0] fet_o,
  output logic [7:0] sw_o
);
  typedef struct packed {
    logic [7:0] fet;
    logic [7:0] sw;
  } sdb_dec_s;
  sdb_dec_s st_reg;
  sdb_dec_s st_next;

  // transistor table; bit0 = T1 ... bit7 = T8
  function automatic logic [7:0] fet_map(input logic [1:0] s, input logic i,
                                         input logic d, input logic r);
    logic [7:0] f;
    f = 8'h00;
    if (i && !d) f = 8'h00;            // integrate without drive: all off [R1]
    else if (!i && !d) begin
      // blanking, no drive: recirculate the integrated coil
      unique case (s)
        2'h0, 2'h2: f = r ? 8'ha0 : 8'h50;
        default: f = r ? 8'h0a : 8'h05;
      endcase
    end else begin
      // drive selected coil for this step [R1]
      unique case (s)
        2'h0: f = i ? 8'h09 : (r ? 8'ha9 : 8'h59);
        2'h1: f = i ? 8'h90 : (r ? 8'h9a : 8'h95);
        2'h2: f = i ? 8'h06 : (r ? 8'ha6 : 8'h56);
        default: f = i ? 8'h60 : (r ? 8'h6a : 8'h65);
      endcase
    end
    return f;
  endfunction : fet_map

  // switch table; bit0 = S1 ... bit7 = S8, two closed when integrating
  function automatic logic [7:0] sw_map(input logic [1:0] s, input logic i,
                                        input logic p);
    logic [7:0] w;
    w = 8'h00;
    if (i) begin
      unique case ({s, p})
        3'h0, 3'h5: w = 8'h90;
        3'h1, 3'h4: w = 8'h60;
        3'h2, 3'h7: w = 8'h06;
        default: w = 8'h09;
      endcase
    end
    return w;
  endfunction : sw_map

  // next state: coils untouched while return to zero is off
  always_comb begin
    st_next = st_reg;
    st_next.fet = rtz_en_i ? fet_map(step_i, itg_i, drive_coil_select_i, recirc_low_side_i) : 8'h00; // [R15] [R1]
    st_next.sw = sw_map(step_i, itg_i, pol_i); // [R2] [R16] [R18]
    if (rst_i) st_next = '0;
  end

  always_ff @(posedge clk_sys_i) begin
    st_reg <= st_next;
  end

  assign fet_o = st_reg.fet;
  assign sw_o = st_reg.sw;

  // integrate clear keeps all switches open
  sw_open_a: assert property (@(posedge clk_sys_i) disable iff (rst_i) // [R2]
    !itg_i |=> sw_o == 8'h00) else $error("switch closed without integrate");
  // integrate set closes exactly two
  sw_two_a: assert property (@(posedge clk_sys_i) disable iff (rst_i) // [R2]
    itg_i |=> $countones(sw_o) == 2) else $error("not two switches closed");
  // integrate without drive turns bridges off
  fet_off_a: assert property (@(posedge clk_sys_i) disable iff (rst_i) // [R1]
    (itg_i && !drive_coil_select_i) |=> fet_o == 8'h00) else $error("bridge on while integrating");
  // no bridge drive without return to zero
  rtz_off_a: assert property (@(posedge clk_sys_i) disable iff (rst_i) // [R15]
    !rtz_en_i |=> fet_o == 8'h00) else $error("bridge on with rtz off");
endmodule : sdb_bridge_dec
`default_nettype wire

//--- hw/sdb_top.sv
`timescale 1ns/1ps
`default_nettype none
// Overview of operation
// R1: bridge enables decoded from step and control bits
// R2: switches open unless integrating; else exactly two
// R3: underflow flag with enable raises interrupt request
// R4: one-shot mode counts down, stops at zero
// R5: auto-reload mode reloads load value at zero
// R6: software clears enable before changing reload mode
// R7: count read gives live or load value
// R8: counter tick is clock over 64 or 512
// R9: new prescale applies only at next reload
// R10: force-reload bit always reads zero
// R11: writing one to force-reload loads counter now; the code loads only while the counter is enabled, a disabled one stays preset
// R12: disabled counter held preset to all ones
// R13: overflow flag with enable raises interrupt request
// R14: control register accessible at any time
// R15: coils driven only with return-to-zero enabled
// R16: integrate clear blanks coil, converter reset
// R17: underflow flag set when counter reaches zero
// R18: step values zero..three are east,north,west,south
// R19: enabled counter drops one per prescaled tick
// R20: interrupt is or of gated flags
module sdb_top (
  input wire logic clk_sys_i,
  input wire logic rst_i,
  input wire logic [2:0] addr_i,
  input wire logic [7:0] wdata_i,
  input wire logic wr_i,
  input wire logic rd_i,
  input wire logic acc_ovf_i,
  output logic [7:0] rdata_o,
  output logic [7:0] fet_en_o,
  output logic [7:0] sw_close_o,
  output logic conv_reset_o,
  output logic irq_o
);
  // all block state in one record
  typedef struct packed {
    logic [7:0] rtz_ctl;     // step, integrate, drive, recirc, polarity
    logic [7:0] cd_ctl;      // countdown_control (force bit kept zero)
    logic rtz_en;            // return_zero_enable
    logic uf_flag;           // underflow_flag
    logic ov_flag;           // overflow_flag
    logic [15:0] load;       // load register
    logic [15:0] count;      // live countdown_value
    logic [8:0] pre_cnt;     // prescaler counter
    logic pre_slow;          // divide setting in force since last load
    logic [7:0] rdata;       // read data register
    logic irq;               // registered interrupt request
    logic conv_rst;          // converter reset while not integrating
    logic ovf_s1;            // sync stage one
    logic ovf_s2;            // sync stage two
  } sdb_state_s;

  sdb_state_s st_reg;
  sdb_state_s st_next;

  logic ctl_wr; // countdown_control write this cycle
  logic cnt_wr; // count low byte write this cycle

  // one write decode shared by every register
  function automatic logic hit(input logic w, input logic [2:0] a, input logic [2:0] r);
    return w && (a == r);
  endfunction : hit

  assign ctl_wr = hit(wr_i, addr_i, sdb_pkg::ADDR_CD_CTL);
  assign cnt_wr = hit(wr_i, addr_i, sdb_pkg::ADDR_CNT_LO);

  // next state of the whole block
  always_comb begin
    logic [8:0] div;
    logic tick;
    logic do_load;
    logic [15:0] ld_val;
    logic uf_set;
    div = 9'h000;
    tick = 1'b0;
    do_load = 1'b0;
    ld_val = 16'h0000;
    uf_set = 1'b0;
    st_next = st_reg;
    // overflow event arrives from the analog side, synchronise it
    st_next.ovf_s1 = acc_ovf_i;
    st_next.ovf_s2 = st_reg.ovf_s1;

    // register writes, accepted in any state [R14]
    if (hit(wr_i, addr_i, sdb_pkg::ADDR_RTZ_CTL)) st_next.rtz_ctl = wdata_i;
    if (ctl_wr) begin
      st_next.cd_ctl = wdata_i;
      st_next.cd_ctl[sdb_pkg::BIT_FORCE] = 1'b0; // stored as zero, reads zero [R10]
    end
    if (hit(wr_i, addr_i, sdb_pkg::ADDR_SSD_CTL)) begin
      st_next.rtz_en = wdata_i[sdb_pkg::BIT_RETURN_ZERO_ENABLE];
    end
    if (hit(wr_i, addr_i, sdb_pkg::ADDR_CNT_HI)) st_next.load[15:8] = wdata_i;
    if (cnt_wr) st_next.load[7:0] = wdata_i;
    ld_val = cnt_wr ? {st_reg.load[15:8], wdata_i} : st_reg.load;

    // prescaler uses the divide latched at the last load [R8] [R9]
    div = st_reg.pre_slow ? sdb_pkg::DIV_SLOW : sdb_pkg::DIV_FAST;
    tick = (st_reg.pre_cnt >= div);
    st_next.pre_cnt = tick ? 9'h000 : st_reg.pre_cnt + 9'h001;

    // countdown engine
    if (!st_reg.cd_ctl[sdb_pkg::BIT_EN]) begin
      st_next.count = sdb_pkg::CNT_PRESET; // held at all ones [R12]
      st_next.pre_cnt = 9'h000;
    end else if (ctl_wr && wdata_i[sdb_pkg::BIT_FORCE]) begin
      do_load = 1'b1; // force reload now; zero write ignored [R11]
    end else if (cnt_wr) begin
      do_load = 1'b1; // count write updates load and counter
    end else if (tick && st_reg.count != sdb_pkg::CNT_ZERO) begin
      st_next.count = st_reg.count - 16'h0001; // one per tick [R19]
      if (st_reg.count == 16'h0001) begin
        uf_set = 1'b1; // reaching zero sets underflow [R17]
      end
    end else if (tick && st_reg.cd_ctl[sdb_pkg::BIT_AUTO]) begin
      do_load = 1'b1; // at zero: reload in auto mode [R5]
    end
    // in one-shot mode a zero count just stays [R4]
    if (do_load) begin
      st_next.count = ld_val;
      st_next.pre_cnt = 9'h000;
      // new divide setting only takes effect here [R9]
      st_next.pre_slow = ctl_wr ? wdata_i[sdb_pkg::BIT_PRE] : st_reg.cd_ctl[sdb_pkg::BIT_PRE];
    end

    // flags: write one clears, a set in the same cycle wins
    if (hit(wr_i, addr_i, sdb_pkg::ADDR_FLAGS)) begin
      if (wdata_i[sdb_pkg::BIT_UF_FLAG]) st_next.uf_flag = 1'b0;
      if (wdata_i[sdb_pkg::BIT_OV_FLAG]) st_next.ov_flag = 1'b0;
    end
    if (uf_set) st_next.uf_flag = 1'b1; // [R17]
    if (st_reg.ovf_s2) st_next.ov_flag = 1'b1;

    // gated flags onto one request [R3] [R13] [R20]
    st_next.irq = (st_next.uf_flag && st_next.cd_ctl[sdb_pkg::BIT_UF_IE]) ||
                  (st_next.ov_flag && st_next.cd_ctl[sdb_pkg::BIT_OV_IE]);
    // converter held reset while not integrating [R16]
    st_next.conv_rst = !st_next.rtz_ctl[sdb_pkg::BIT_ITG];

    // read data, valid the cycle after the strobe only
    st_next.rdata = 8'h00;
    if (rd_i) begin
      unique case (addr_i)
        sdb_pkg::ADDR_RTZ_CTL: st_next.rdata = st_reg.rtz_ctl & 8'hf3;
        sdb_pkg::ADDR_CD_CTL: st_next.rdata = st_reg.cd_ctl & 8'hf5; // force reads zero [R10]
        sdb_pkg::ADDR_SSD_CTL: st_next.rdata = {st_reg.rtz_en, 7'h00};
        sdb_pkg::ADDR_FLAGS: st_next.rdata = {st_reg.uf_flag, 6'h00, st_reg.ov_flag};
        sdb_pkg::ADDR_CNT_HI: st_next.rdata = st_reg.cd_ctl[sdb_pkg::BIT_RDLOAD] ?
          st_reg.load[15:8] : st_reg.count[15:8]; // [R7]
        sdb_pkg::ADDR_CNT_LO: st_next.rdata = st_reg.cd_ctl[sdb_pkg::BIT_RDLOAD] ?
          st_reg.load[7:0] : st_reg.count[7:0]; // [R7]
        default: st_next.rdata = 8'h00; // unmapped reads zero
      endcase
    end

    if (rst_i) begin
      st_next = '0;
      st_next.cd_ctl = sdb_pkg::RST_CTL;
      st_next.count = sdb_pkg::CNT_PRESET;
      st_next.load = sdb_pkg::CNT_PRESET;
      st_next.conv_rst = 1'b1;
    end
  end

  always_ff @(posedge clk_sys_i) begin
    st_reg <= st_next;
  end

  // bridge and switch decode, registered inside
  sdb_bridge_dec u_dec (
    .clk_sys_i(clk_sys_i),
    .rst_i(rst_i),
    .rtz_en_i(st_reg.rtz_en),
    .step_i(st_reg.rtz_ctl[1:0]),
    .itg_i(st_reg.rtz_ctl[sdb_pkg::BIT_ITG]),
    .drive_coil_select_i(st_reg.rtz_ctl[sdb_pkg::BIT_DRIVE_COIL_SELECT]),
    .recirc_low_side_i(st_reg.rtz_ctl[sdb_pkg::BIT_RECIRC_LOW_SIDE]),
    .pol_i(st_reg.rtz_ctl[sdb_pkg::BIT_POL]),
    .fet_o(fet_en_o),
    .sw_o(sw_close_o)
  );

  assign rdata_o = st_reg.rdata;
  assign irq_o = st_reg.irq;
  assign conv_reset_o = st_reg.conv_rst;

  // sequences for the countdown checks
  sequence dis_s;
    !st_reg.cd_ctl[sdb_pkg::BIT_EN];
  endsequence
  sequence reach_zero_s;
    st_reg.cd_ctl[sdb_pkg::BIT_EN] && st_reg.count == 16'h0001 && !ctl_wr && !cnt_wr &&
      (st_reg.pre_cnt >= (st_reg.pre_slow ? sdb_pkg::DIV_SLOW : sdb_pkg::DIV_FAST));
  endsequence

  preset_hold_a: assert property (@(posedge clk_sys_i) disable iff (rst_i) // [R12]
    dis_s |=> st_reg.count == 16'hffff) else $error("counter not preset while disabled");
  uf_set_a: assert property (@(posedge clk_sys_i) disable iff (rst_i) // [R17]
    reach_zero_s |=> st_reg.uf_flag && st_reg.count == 16'h0000) else $error("no underflow flag");
  stay_zero_a: assert property (@(posedge clk_sys_i) disable iff (rst_i) // [R4]
    (st_reg.count == 16'h0000 && st_reg.cd_ctl[sdb_pkg::BIT_EN] &&
     !st_reg.cd_ctl[sdb_pkg::BIT_AUTO] && !wr_i) |=> st_reg.count == 16'h0000)
    else $error("one-shot counter left zero");
  force_load_a: assert property (@(posedge clk_sys_i) disable iff (rst_i) // [R11]
    (ctl_wr && wdata_i[sdb_pkg::BIT_FORCE] && st_reg.cd_ctl[sdb_pkg::BIT_EN])
    |=> st_reg.count == $past(st_reg.load)) else $error("force reload missed");
  force_rd_a: assert property (@(posedge clk_sys_i) disable iff (rst_i) // [R10]
    (rd_i && addr_i == sdb_pkg::ADDR_CD_CTL) |=> !rdata_o[sdb_pkg::BIT_FORCE])
    else $error("force bit read as one");
  irq_gate_a: assert property (@(posedge clk_sys_i) disable iff (rst_i) // [R20]
    irq_o == ((st_reg.uf_flag && st_reg.cd_ctl[sdb_pkg::BIT_UF_IE]) ||
              (st_reg.ov_flag && st_reg.cd_ctl[sdb_pkg::BIT_OV_IE])))
    else $error("interrupt not or of gated flags");
  rd_live_a: assert property (@(posedge clk_sys_i) disable iff (rst_i) // [R7]
    (rd_i && addr_i == sdb_pkg::ADDR_CNT_LO) |=> rdata_o == ($past(st_reg.cd_ctl[5]) ?
      $past(st_reg.load[7:0]) : $past(st_reg.count[7:0]))) else $error("count read wrong");
  step_one_a: assert property (@(posedge clk_sys_i) disable iff (rst_i) // [R19]
    (st_reg.cd_ctl[sdb_pkg::BIT_EN] && !wr_i && st_reg.count > 16'h0001 &&
     st_reg.pre_cnt == 9'h000) |=> st_reg.count == $past(st_reg.count))
    else $error("counter moved between ticks");

  // sitting at zero in auto mode with a tick due and no write in the way
  sequence reload_due_s;
    st_reg.cd_ctl[sdb_pkg::BIT_EN] && st_reg.cd_ctl[sdb_pkg::BIT_AUTO] &&
      st_reg.count == 16'h0000 && !ctl_wr && !cnt_wr &&
      (st_reg.pre_cnt >= (st_reg.pre_slow ? sdb_pkg::DIV_SLOW : sdb_pkg::DIV_FAST));
  endsequence

  // ordinary decrement: enabled, above one, tick due, no write in the way
  sequence step_due_s;
    st_reg.cd_ctl[sdb_pkg::BIT_EN] && st_reg.count > 16'h0001 && !ctl_wr && !cnt_wr &&
      (st_reg.pre_cnt >= (st_reg.pre_slow ? sdb_pkg::DIV_SLOW : sdb_pkg::DIV_FAST));
  endsequence

  // no load possible: no count or control write and a count off zero
  sequence no_load_s;
    !ctl_wr && !cnt_wr && st_reg.count != 16'h0000;
  endsequence

  // auto mode at zero takes the stored load value on the tick
  auto_reload_a: assert property (@(posedge clk_sys_i) disable iff (rst_i) // [R5]
    reload_due_s |=> st_reg.count == $past(st_reg.load)) else $error("auto reload missed");

  // exactly one step down per prescaled tick
  step_dec_a: assert property (@(posedge clk_sys_i) disable iff (rst_i) // [R19]
    step_due_s |=> st_reg.count == $past(st_reg.count) - 16'h0001)
    else $error("counter did not drop by one");

  // divide setting only moves on a load; a control write without the force bit moves it only at the next count write, force reload or auto reload
  pre_hold_a: assert property (@(posedge clk_sys_i) disable iff (rst_i) // [R9]
    no_load_s |=> st_reg.pre_slow == $past(st_reg.pre_slow))
    else $error("prescale changed without a load");

  // fast divide never lets the prescaler run past its end count
  pre_fast_a: assert property (@(posedge clk_sys_i) disable iff (rst_i) // [R8]
    !st_reg.pre_slow |-> st_reg.pre_cnt <= sdb_pkg::DIV_FAST)
    else $error("fast prescaler overran");

  // the force bit is never kept, so it can never read back as one
  force_zero_a: assert property (@(posedge clk_sys_i) disable iff (rst_i) // [R10]
    !st_reg.cd_ctl[sdb_pkg::BIT_FORCE]) else $error("force bit stored");

  // a control write lands on the next edge whatever the counter is doing
  ctl_write_a: assert property (@(posedge clk_sys_i) disable iff (rst_i) // [R14]
    ctl_wr |=> st_reg.cd_ctl == ($past(wdata_i) & 8'hf7))
    else $error("control write lost");

  // enabled underflow flag always shows on the request line
  uf_irq_a: assert property (@(posedge clk_sys_i) disable iff (rst_i) // [R3]
    (st_reg.uf_flag && st_reg.cd_ctl[sdb_pkg::BIT_UF_IE]) |-> irq_o)
    else $error("underflow request missing");

  // masked underflow alone never raises a request
  uf_mask_a: assert property (@(posedge clk_sys_i) disable iff (rst_i) // [R3]
    (!st_reg.cd_ctl[sdb_pkg::BIT_UF_IE] && !st_reg.ov_flag) |-> !irq_o)
    else $error("masked underflow requested");

  // enabled overflow flag always shows on the request line
  ov_irq_a: assert property (@(posedge clk_sys_i) disable iff (rst_i) // [R13]
    (st_reg.ov_flag && st_reg.cd_ctl[sdb_pkg::BIT_OV_IE]) |-> irq_o)
    else $error("overflow request missing");

  // masked overflow alone never raises a request
  ov_mask_a: assert property (@(posedge clk_sys_i) disable iff (rst_i) // [R13]
    (!st_reg.cd_ctl[sdb_pkg::BIT_OV_IE] && !st_reg.uf_flag) |-> !irq_o)
    else $error("masked overflow requested");

  // converter reset follows the integrate bit with no extra lag
  conv_rst_a: assert property (@(posedge clk_sys_i) disable iff (rst_i) // [R16]
    conv_reset_o == !st_reg.rtz_ctl[sdb_pkg::BIT_ITG])
    else $error("converter reset wrong");

  // high byte read picks live count or load just like the low byte
  rd_high_a: assert property (@(posedge clk_sys_i) disable iff (rst_i) // [R7]
    (rd_i && addr_i == sdb_pkg::ADDR_CNT_HI) |=> rdata_o == ($past(st_reg.cd_ctl[5]) ?
      $past(st_reg.load[15:8]) : $past(st_reg.count[15:8]))) else $error("high read wrong");

  // read data stands one cycle only, zero otherwise
  rd_idle_a: assert property (@(posedge clk_sys_i) disable iff (rst_i) // [R14]
    !rd_i |=> rdata_o == 8'h00) else $error("read data left standing");
endmodule : sdb_top
`default_nettype wire

//--- verif/sdb_coil_model.sv
`timescale 1ns/1ps
`default_nettype none
// far side: coils and converter front end, raises an accumulator overflow on request while integrating
module sdb_coil_model (
  input wire logic clk_sys_i,
  input wire logic [7:0] sw_close_i,
  input wire logic conv_reset_i,
  input wire logic ovf_req_i,
  output logic acc_ovf_o
);
  // idle low from time zero so the design never sees an unknown
  initial acc_ovf_o = 1'b0;
  // overflow only while integrating: converter out of reset, two nodes routed
  always @(posedge clk_sys_i) begin
    acc_ovf_o <= ovf_req_i && !conv_reset_i && ($countones(sw_close_i) == 2);
  end
endmodule : sdb_coil_model
`default_nettype wire

//--- verif/testbench.sv
`timescale 1ns/1ps
`default_nettype none
// self-checking bench for the bridge decode and countdown block
module testbench;
  localparam logic [2:0] A_RTZ = sdb_pkg::ADDR_RTZ_CTL;
  localparam logic [2:0] A_CD = sdb_pkg::ADDR_CD_CTL;
  localparam logic [2:0] A_SSD = sdb_pkg::ADDR_SSD_CTL;
  localparam logic [2:0] A_FLG = sdb_pkg::ADDR_FLAGS;
  localparam logic [2:0] A_HI = sdb_pkg::ADDR_CNT_HI;
  localparam logic [2:0] A_LO = sdb_pkg::ADDR_CNT_LO;
  logic clk_sys_i, rst_i, wr_i, rd_i, ovf_req, acc_ovf, conv_reset_o, irq_o;
  logic [2:0] addr_i;
  logic [7:0] wdata_i, rdata_o, fet_en_o, sw_close_o, v;
  logic [15:0] c;
  int errors = 0;
  int n_tests = 0;
  // bridge enables, index {step, itg, drive_coil_select, recirc_low_side}
  logic [7:0] fet_tab [32] = '{8'h50, 8'ha0, 8'h59, 8'ha9, 8'h00, 8'h00, 8'h09, 8'h09,
    8'h05, 8'h0a, 8'h95, 8'h9a, 8'h00, 8'h00, 8'h90, 8'h90,
    8'h50, 8'ha0, 8'h56, 8'ha6, 8'h00, 8'h00, 8'h06, 8'h06,
    8'h05, 8'h0a, 8'h65, 8'h6a, 8'h00, 8'h00, 8'h60, 8'h60};
  // switch closures while integrating, index {step, pol}
  logic [7:0] sw_tab [8] = '{8'h90, 8'h60, 8'h06, 8'h09, 8'h60, 8'h90, 8'h09, 8'h06};

  sdb_top i_dut (.clk_sys_i(clk_sys_i), .rst_i(rst_i), .addr_i(addr_i), .wdata_i(wdata_i),
    .wr_i(wr_i), .rd_i(rd_i), .acc_ovf_i(acc_ovf), .rdata_o(rdata_o), .fet_en_o(fet_en_o),
    .sw_close_o(sw_close_o), .conv_reset_o(conv_reset_o), .irq_o(irq_o));
  sdb_coil_model i_coil (.clk_sys_i(clk_sys_i), .sw_close_i(sw_close_o),
    .conv_reset_i(conv_reset_o), .ovf_req_i(ovf_req), .acc_ovf_o(acc_ovf));

  // 200 MHz system clock
  initial begin
    clk_sys_i = 1'b0;
    forever #2.5 clk_sys_i = ~clk_sys_i;
  end

  task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
    n_tests++;
    if (got !== exp) begin
      errors++;
      $display("wrong value %s expected %h seen %h", what, exp, got);
    end
  endtask : chk

  // one-cycle write strobe, released on the edge that samples it
  task automatic wr(input logic [2:0] a, input logic [7:0] d);
    @(posedge clk_sys_i);
    addr_i <= a;
    wdata_i <= d;
    wr_i <= 1'b1;
    @(posedge clk_sys_i);
    wr_i <= 1'b0;
  endtask : wr

  // read data stands only in the cycle after the strobe
  task automatic rd(input logic [2:0] a, output logic [7:0] d);
    @(posedge clk_sys_i);
    addr_i <= a;
    rd_i <= 1'b1;
    @(posedge clk_sys_i);
    rd_i <= 1'b0;
    #1 d = rdata_o;
  endtask : rd

  // halves read apart; callers sample mid-tick so no tick splits them
  task automatic rdcnt(output logic [15:0] q);
    rd(A_HI, q[15:8]);
    rd(A_LO, q[7:0]);
  endtask : rdcnt

  task automatic cyc(input int n);
    repeat (n) @(posedge clk_sys_i);
    #1;
  endtask : cyc

  task automatic print_verdict;
    if (errors == 0 && n_tests > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask : print_verdict

  // values straight after reset
  task automatic t_reset;
    rd(A_CD, v);
    chk("ctl", 16'h0000, {8'h00, v});
    rdcnt(c);
    chk("count", 16'hffff, c);
    chk("fets", 16'h0000, {8'h00, fet_en_o});
    chk("conv_reset", 16'h0001, {15'h0, conv_reset_o});
    chk("irq", 16'h0000, {15'h0, irq_o});
  endtask : t_reset

  // every step, integrate, drive and recirculation combination
  task automatic t_bridge;
    wr(A_SSD, 8'h80);
    for (int i = 0; i < 32; i++) begin
      wr(A_RTZ, {i[2], i[1], i[0], 3'b000, i[4:3]});
      cyc(2);
      chk("fets", {8'h00, fet_tab[i]}, {8'h00, fet_en_o});
    end
    wr(A_SSD, 8'h00);
    wr(A_RTZ, 8'h40);
    cyc(2);
    chk("fets off", 16'h0000, {8'h00, fet_en_o});
  endtask : t_bridge

  // switch routing with return-to-zero both off and on
  task automatic t_switch;
    for (int r = 0; r < 2; r++) begin
      wr(A_SSD, {r[0], 7'h00});
      for (int j = 0; j < 16; j++) begin
        wr(A_RTZ, {j[3], 2'b00, j[0], 2'b00, j[2:1]});
        cyc(2);
        chk("sw", {8'h00, j[3] ? sw_tab[j[2:0]] : 8'h00}, {8'h00, sw_close_o});
        chk("conv_reset", {15'h0, !j[3]}, {15'h0, conv_reset_o});
      end
    end
  endtask : t_switch

  // one-shot count to zero, masked then unmasked underflow, load readback
  task automatic t_oneshot;
    wr(A_CD, 8'h04);
    wr(A_HI, 8'h00);
    wr(A_LO, 8'h03);
    cyc(28);
    rdcnt(c);
    chk("count", 16'h0003, c);
    for (int k = 2; k >= 0; k--) begin
      cyc(60);
      rdcnt(c);
      chk("count", 16'(k), c);
    end
    rd(A_FLG, v);
    chk("flags", 16'h0080, {8'h00, v});
    chk("irq masked", 16'h0000, {15'h0, irq_o});
    cyc(60);
    rdcnt(c);
    chk("count held", 16'h0000, c);
    wr(A_CD, 8'h84);
    cyc(2);
    chk("irq", 16'h0001, {15'h0, irq_o});
    wr(A_FLG, 8'h80);
    cyc(2);
    chk("irq cleared", 16'h0000, {15'h0, irq_o});
    wr(A_CD, 8'h24);
    rdcnt(c);
    chk("load value", 16'h0003, c);
    rd(A_CD, v);
    chk("ctl", 16'h0024, {8'h00, v});
    wr(A_CD, 8'h00);
    rdcnt(c);
    chk("count off", 16'hffff, c);
  endtask : t_oneshot

  // slow prescale waits for a load, then force reload applies it
  task automatic t_prescale;
    wr(A_CD, 8'h04);
    wr(A_HI, 8'h00);
    wr(A_LO, 8'h10);
    cyc(28);
    rdcnt(c);
    chk("count", 16'h0010, c);
    wr(A_CD, 8'h14);
    cyc(58);
    rdcnt(c);
    chk("count fast", 16'h000f, c);
    cyc(60);
    rdcnt(c);
    chk("count fast", 16'h000e, c);
    wr(A_CD, 8'h1c);
    rd(A_CD, v);
    chk("ctl force", 16'h0014, {8'h00, v});
    cyc(250);
    rdcnt(c);
    chk("count reload", 16'h0010, c);
    cyc(508);
    rdcnt(c);
    chk("count slow", 16'h000f, c);
    wr(A_CD, 8'h00);
  endtask : t_prescale

  // auto-reload: enable cleared beforehand, reload after zero
  task automatic t_auto;
    wr(A_CD, 8'h44);
    wr(A_HI, 8'h00);
    wr(A_LO, 8'h02);
    cyc(28);
    for (int k = 0; k < 4; k++) begin
      rdcnt(c);
      chk("count auto", (k == 3) ? 16'h0002 : 16'(2 - k), c);
      cyc(60);
    end
    rd(A_FLG, v);
    chk("flags", 16'h0080, {8'h00, v});
    wr(A_FLG, 8'h80);
    wr(A_CD, 8'h00);
  endtask : t_auto

  // overflow from the coil side, masked then unmasked, plus unmapped reads
  task automatic t_ovf;
    wr(A_RTZ, 8'h80);
    @(posedge clk_sys_i);
    ovf_req <= 1'b1;
    @(posedge clk_sys_i);
    ovf_req <= 1'b0;
    cyc(5);
    rd(A_FLG, v);
    chk("flags", 16'h0001, {8'h00, v});
    chk("irq masked", 16'h0000, {15'h0, irq_o});
    wr(A_CD, 8'h01);
    cyc(2);
    chk("irq", 16'h0001, {15'h0, irq_o});
    wr(A_FLG, 8'h01);
    cyc(2);
    chk("irq cleared", 16'h0000, {15'h0, irq_o});
    rd(3'h6, v);
    chk("unmapped", 16'h0000, {8'h00, v});
  endtask : t_ovf

  // main sequence: reset held 20 cycles, then each scenario
  initial begin
    rst_i = 1'b1;
    wr_i = 1'b0;
    rd_i = 1'b0;
    ovf_req = 1'b0;
    addr_i = 3'h0;
    wdata_i = 8'h00;
    repeat (20) @(posedge clk_sys_i);
    rst_i <= 1'b0;
    t_reset();
    t_bridge();
    t_switch();
    t_oneshot();
    t_prescale();
    t_auto();
    t_ovf();
    print_verdict();
  end

  // the whole run needs a few thousand cycles; this cuts a hang short
  initial begin
    repeat (20000) @(posedge clk_sys_i);
    errors++;
    print_verdict();
  end
endmodule : testbench
`default_nettype wire
